// File: flash_bank_decode.v
// bank decoding and boot-block guard decoding
`timescale 1ns/1ps
`include "flash_bank_defines.vh"
module flash_bank_decode (
	input wire topBoot,
	input wire [1:0] highBits,
	input wire [`SECT_W-1:0] sector,
	output wire bank2,
	output wire smallBank,
	output wire bootGuard
);
	// top: 00 bank1, else bank2; bottom: 11 bank2 only
	assign bank2 = topBoot ? (highBits != 2'h0) : (highBits == 2'h3);
	// top: bank1 small; bottom: bank2 small
	assign smallBank = topBoot ? ~bank2 : bank2;
	// two outermost sectors of the boot end
	assign bootGuard = topBoot ? (sector >= 4'hE) : (sector <= 4'h1);
endmodule

// File: flash_bank_defines.vh
// constants for the dual-bank flash bus front end
`ifndef FLASH_BANK_DEFINES_VH
`define FLASH_BANK_DEFINES_VH
`define ADDR_W 20
`define WORD_ADDR_W 19
`define DATA_W 32
`define HALF_W 16
`define ID_W 8
// command codes seen on the low data byte
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_AUTOSEL 8'h90
`define CMD_PROGRAM 8'hA0
`define CMD_BYPASS 8'h20
`define CMD_BYPASS_EXIT 8'h00
`define CMD_ERASE 8'h80
`define CMD_SECT_ERASE 8'h30
`define CMD_CHIP_ERASE 8'h10
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hF0
`define CMD_CFI 8'h98
`define CMD_PWD 8'h38
`define CMD_LOCKPROG 8'hC0
// autoselect internal register codes
`define ID_MFR_ADDR 8'h00
`define ID_DEV_ADDR 8'h01
`define ID_BOOT_ADDR 8'h0F
`define ID_LOCK_ADDR 8'h02
// embedded operation length in clock cycles
`define OP_CYCLES 16'h0040
`define SECT_SHIFT 15
`define SECT_W 4
`endif

// File: flash_bank_mem.v
// little array model: word storage with registered read data
`timescale 1ns/1ps
module flash_bank_mem #(
	parameter AW = 6,
	parameter DW = 32
) (
	input wire core_clk,
	input wire ce,
	input wire wrEn,
	input wire [AW-1:0] wrAddr,
	input wire [DW-1:0] wrData,
	input wire [AW-1:0] rdAddr,
	output reg [DW-1:0] rdData
);
	reg [DW-1:0] cells [0:(1<<AW)-1];

	always @(posedge core_clk) begin
		if (ce) begin
			if (wrEn) begin
				cells[wrAddr] <= wrData;
			end
			rdData <= cells[rdAddr];
		end
	end
endmodule

// File: flash_bus_bank_access.v
// flash bus front end: read/write decoding, command sequencer, banks
`timescale 1ns/1ps
`include "flash_bank_defines.vh"
module flash_bus_bank_access #(
	parameter MEM_AW = 6,
	parameter OP_LEN = `OP_CYCLES
) (
	input wire core_clk,
	input wire sys_rst,
	input wire clkEn,
	input wire hwReset_n,
	input wire chipSel_n,
	input wire outGate_n,
	input wire writeStrobe_n,
	input wire wideBus,
	input wire topBoot,
	input wire writeProtect_n,
	input wire accel_voltage_pin,
	input wire secured_otp_sector,
	input wire [`ADDR_W-1:0] addr,
	input wire [`DATA_W-1:0] dataIn,
	output reg [`DATA_W-1:0] dataOut,
	output reg [`DATA_W-1:0] dataOe,
	output reg readyBusy,
	output reg bypassMode,
	output reg idMode,
	output reg eraseSuspended,
	output reg simulDisabled
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam S_READ = 7'h01;
	localparam S_UL1 = 7'h02;
	localparam S_UL2 = 7'h04;
	localparam S_PROG = 7'h08;
	localparam S_ER1 = 7'h10;
	localparam S_ER2 = 7'h20;
	localparam S_ER3 = 7'h40;

	reg [6:0] state;
	reg [6:0] next_state;
	reg busy;
	reg busyBank2;
	reg erasing;
	reg [15:0] opCount;
	reg [15:0] eraseMask;
	reg [`SECT_W-1:0] suspSector;
	reg [15:0] lockPersist;
	reg [15:0] lockDynamic;
	reg cfiMode;
	reg pwdMode;
	reg lockOp;
	reg prevWrite;
	reg [`WORD_ADDR_W-1:0] rdWord;
	reg rdHalfHi;
	reg [`DATA_W-1:0] progData;
	reg [`WORD_ADDR_W-1:0] progAddr;

	// ----------------------------------------
	// address and data shaping
	// ----------------------------------------
	// in half-word mode addr[0] is the extra low bit, word address above it
	wire [`WORD_ADDR_W-1:0] wordAddr = wideBus ? addr[`WORD_ADDR_W-1:0] :
		addr[`ADDR_W-1:1];
	wire halfHi = ~wideBus & addr[0];
	wire [1:0] highBits = wordAddr[`WORD_ADDR_W-1:`WORD_ADDR_W-2];
	wire [`SECT_W-1:0] sector = wordAddr[`WORD_ADDR_W-1:`SECT_SHIFT];
	wire [7:0] cmd = dataIn[7:0];
	wire writeCyc = ~chipSel_n & ~writeStrobe_n & outGate_n;
	wire readCyc = ~chipSel_n & ~outGate_n & writeStrobe_n;
	wire writeEdge = writeCyc & ~prevWrite;
	wire bank2;
	wire smallBank;
	wire bootGuard;
	wire [`DATA_W-1:0] memRd;
	wire progFire = writeEdge & (state == S_PROG) & ~busy;
	wire guarded = (bootGuard & ~writeProtect_n) | lockDynamic[sector] | lockPersist[sector];
	wire memWr = busy & (opCount == 16'h0001) & ~erasing;

	flash_bank_decode u_decode (
		.topBoot(topBoot),
		.highBits(highBits),
		.sector(sector),
		.bank2(bank2),
		.smallBank(smallBank),
		.bootGuard(bootGuard)
	);

	flash_bank_mem #(.AW(MEM_AW), .DW(`DATA_W)) u_mem (
		.core_clk(core_clk),
		.ce(clkEn),
		.wrEn(memWr),
		.wrAddr(progAddr[MEM_AW-1:0]),
		.wrData(progData),
		.rdAddr(wordAddr[MEM_AW-1:0]),
		.rdData(memRd)
	);

	// pads a half word with all-ones in the other half for 16-bit programming
	function [`DATA_W-1:0] mergeHalf;
		input hi;
		input [`HALF_W-1:0] half;
		begin
			mergeHalf = hi ? {half, {`HALF_W{1'b1}}} : {{`HALF_W{1'b1}}, half};
		end
	endfunction

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always @* begin
		next_state = state;
		if (writeEdge) begin
			case (state)
				S_READ: begin
					if (bypassMode && cmd == `CMD_PROGRAM) next_state = S_PROG;
					else if (cmd == `CMD_UNLOCK1) next_state = S_UL1;
				end
				S_UL1: next_state = (cmd == `CMD_UNLOCK2) ? S_UL2 : S_READ;
				S_UL2: begin
					case (cmd)
						`CMD_PROGRAM: next_state = S_PROG;
						`CMD_ERASE: next_state = S_ER1;
						default: next_state = S_READ;
					endcase
				end
				S_PROG: next_state = S_READ;
				S_ER1: next_state = (cmd == `CMD_UNLOCK1) ? S_ER2 : S_READ;
				S_ER2: next_state = (cmd == `CMD_UNLOCK2) ? S_ER3 : S_READ;
				S_ER3: next_state = S_READ;
				default: next_state = S_READ;
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst || !hwReset_n) begin
			// both resets abort and return to array read
			state <= S_READ;
			busy <= 1'b0;
			busyBank2 <= 1'b0;
			erasing <= 1'b0;
			opCount <= 16'h0000;
			eraseMask <= 16'h0000;
			suspSector <= {`SECT_W{1'b0}};
			lockDynamic <= 16'h0000;
			cfiMode <= 1'b0;
			pwdMode <= 1'b0;
			lockOp <= 1'b0;
			prevWrite <= 1'b0;
			bypassMode <= 1'b0;
			idMode <= 1'b0;
			eraseSuspended <= 1'b0;
			progAddr <= {`WORD_ADDR_W{1'b0}};
			progData <= {`DATA_W{1'b0}};
		end else if (clkEn) begin
			prevWrite <= writeCyc;
			state <= next_state;
			if (accel_voltage_pin) begin
				bypassMode <= 1'b1;
			end
			if (writeEdge) begin
				if (state == S_UL2) begin
					if (cmd == `CMD_AUTOSEL) idMode <= 1'b1;
					if (cmd == `CMD_BYPASS) bypassMode <= 1'b1;
					if (cmd == `CMD_PWD) pwdMode <= 1'b1;
					if (cmd == `CMD_LOCKPROG) lockOp <= 1'b1;
				end
				if (state == S_READ) begin
					if (cmd == `CMD_CFI) cfiMode <= 1'b1;
					if (cmd == `CMD_RESET) begin
						idMode <= 1'b0;
						cfiMode <= 1'b0;
						pwdMode <= 1'b0;
						lockOp <= 1'b0;
					end
					if (bypassMode && cmd == `CMD_BYPASS_EXIT && !accel_voltage_pin)
						bypassMode <= 1'b0;
					if (cmd == `CMD_SUSPEND && busy && erasing) begin
						busy <= 1'b0;
						eraseSuspended <= 1'b1;
					end
					if (cmd == `CMD_RESUME && eraseSuspended && !busy) begin
						busy <= 1'b1;
						eraseSuspended <= 1'b0;
					end
				end
				// sector erase starts on the first sector command; only one sector per erase
				if (state == S_ER3 && !busy) begin
					erasing <= 1'b1;
					busy <= 1'b1;
					opCount <= OP_LEN[15:0];
					busyBank2 <= bank2;
					if (cmd == `CMD_CHIP_ERASE) eraseMask <= 16'hFFFF;
					else if (!guarded) eraseMask <= eraseMask | (16'h0001 << sector);
					suspSector <= sector;
				end
			end
			// programming: 32-bit word or merged 16-bit half word
			if (progFire && !guarded && !(eraseSuspended && sector == suspSector)) begin
				busy <= 1'b1;
				erasing <= 1'b0;
				opCount <= OP_LEN[15:0];
				busyBank2 <= bank2;
				progAddr <= wordAddr;
				progData <= wideBus ? dataIn : mergeHalf(halfHi, dataIn[`HALF_W-1:0]);
			end
			if (busy && opCount != 16'h0000) begin
				opCount <= opCount - 16'h0001;
				if (opCount == 16'h0001) begin
					busy <= 1'b0;
					erasing <= 1'b0;
					eraseMask <= 16'h0000;
					lockOp <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// read path and pin drive
	// ----------------------------------------
	// a busy bank returns status; simultaneous access off under query/password
	wire bankBlocked = busy & ((bank2 == busyBank2) | simulDisabled);
	wire [`DATA_W-1:0] status = {{(`DATA_W-1){1'b0}}, ~busy};
	reg [`DATA_W-1:0] next_dataOut;
	reg [`DATA_W-1:0] rawWord;

	always @* begin
		rawWord = memRd;
		if (idMode) begin
			case (wordAddr[7:0])
				`ID_LOCK_ADDR: rawWord = {30'h0, lockDynamic[sector], lockPersist[sector]};
				`ID_BOOT_ADDR: rawWord = {31'h0, ~topBoot};
				default: rawWord = {24'h0, wordAddr[7:0] ^ 8'h5A}; // arbitrary id codes
			endcase
			rawWord = {24'h0, rawWord[7:0]};
		end else if (lockOp && smallBank) begin
			rawWord = status;
		end else if (bankBlocked && !secured_otp_sector) begin
			rawWord = status;
		end else if (bankBlocked) begin
			rawWord = status;
		end
		next_dataOut = (halfHi) ? {16'h0, rawWord[31:16]} : rawWord;
	end

	always @(posedge core_clk) begin
		if (sys_rst || !hwReset_n) begin
			dataOut <= 32'h0000_0000;
			dataOe <= 32'h0000_0000;
			readyBusy <= 1'b1;
			simulDisabled <= 1'b0;
			lockPersist <= 16'h0000;
			rdWord <= {`WORD_ADDR_W{1'b0}};
			rdHalfHi <= 1'b0;
		end else if (clkEn) begin
			rdWord <= wordAddr;
			rdHalfHi <= halfHi;
			dataOut <= next_dataOut;
			dataOe[15:0] <= {16{readCyc}};
			dataOe[31:16] <= {16{readCyc & wideBus}};
			readyBusy <= ~busy;
			simulDisabled <= cfiMode | pwdMode;
			if (lockOp && memWr) lockPersist[progAddr[`WORD_ADDR_W-1:`SECT_SHIFT]] <= 1'b1;
		end
	end
endmodule

// File: flash_bus_bank_access_assertions.sv
// port checks for the flash bus front end
`timescale 1ns/1ps
module flash_bus_bank_access_assertions #(
	parameter OP_LEN = 64
) (
	input wire core_clk,
	input wire sys_rst,
	input wire hwReset_n,
	input wire chipSel_n,
	input wire outGate_n,
	input wire writeStrobe_n,
	input wire wideBus,
	input wire accel_voltage_pin,
	input wire [31:0] dataOe,
	input wire readyBusy,
	input wire bypassMode,
	input wire idMode,
	input wire eraseSuspended
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	reg [15:0] busyCnt;
	reg cut;
	reg prevRdy;
	reg wasSusp;
	// a reset in mid-operation ends it early, so that span is not measured
	always @(posedge core_clk) begin
		busyCnt <= readyBusy ? 16'h0000 : busyCnt + 16'h0001;
		cut <= readyBusy ? 1'b0 : cut | ~hwReset_n;
		prevRdy <= readyBusy;
		// a suspended erase splits its busy span until the final rise
		wasSusp <= sys_rst ? 1'b0 : eraseSuspended | (wasSusp & ~(readyBusy & ~prevRdy));
	end
	sequence s_read;
		hwReset_n && !chipSel_n && !outGate_n && writeStrobe_n;
	endsequence
	sequence s_write;
		!chipSel_n && !writeStrobe_n && outGate_n;
	endsequence
	a_reset_quiet: assert property (!hwReset_n |=> dataOe == 32'h00000000 && readyBusy
		&& !idMode && !bypassMode) else $error("reset left state");
	a_half_float: assert property (!$past(wideBus) |-> dataOe[31:16] == 16'h0000)
		else $error("upper lanes driven");
	a_wide_drive: assert property (s_read ##0 wideBus |=> dataOe == 32'hFFFFFFFF)
		else $error("wide read not driven");
	a_half_drive: assert property (s_read ##0 !wideBus |=> dataOe == 32'h0000FFFF)
		else $error("half read lanes wrong");
	a_idle_float: assert property (chipSel_n |=> dataOe == 32'h00000000)
		else $error("driven while deselected");
	a_write_float: assert property (s_write |=> dataOe == 32'h00000000)
		else $error("driven during write");
	a_busy_span: assert property ($rose(readyBusy) && !cut && !wasSusp && !eraseSuspended
		|-> busyCnt == OP_LEN)
		else $error("busy span wrong");
	a_accel_bypass: assert property ($rose(accel_voltage_pin) && hwReset_n
		|-> ##[1:3] bypassMode) else $error("no bypass on high voltage");
endmodule
bind flash_bus_bank_access flash_bus_bank_access_assertions #(.OP_LEN(OP_LEN)) i_chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .hwReset_n(hwReset_n), .chipSel_n(chipSel_n),
	.outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n), .wideBus(wideBus),
	.accel_voltage_pin(accel_voltage_pin), .dataOe(dataOe), .readyBusy(readyBusy),
	.bypassMode(bypassMode), .idMode(idMode), .eraseSuspended(eraseSuspended));

// File: flash_bus_bank_access_tb.sv
// self-checking bench for the flash bus front end
`timescale 1ns/1ps
`include "flash_bank_defines.vh"
module flash_bus_bank_access_tb;
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg hwReset_n = 1'b1;
	reg wideBus = 1'b1;
	reg topBoot = 1'b1;
	reg writeProtect_n = 1'b1;
	reg accel_voltage_pin = 1'b0;
	wire chipSel_n, outGate_n, writeStrobe_n, readyBusy, bypassMode, idMode;
	wire eraseSuspended, simulDisabled;
	wire [19:0] addr;
	wire [31:0] dataIn, dataOut, dataOe;
	integer err_total = 0;
	integer checks = 0;
	reg [31:0] rv;
	always #5 core_clk = ~core_clk;
	flash_bus_bank_access #(.MEM_AW(6), .OP_LEN(16)) i_dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1), .hwReset_n(hwReset_n),
		.chipSel_n(chipSel_n), .outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n),
		.wideBus(wideBus), .topBoot(topBoot), .writeProtect_n(writeProtect_n),
		.accel_voltage_pin(accel_voltage_pin), .secured_otp_sector(1'b0), .addr(addr),
		.dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .readyBusy(readyBusy),
		.bypassMode(bypassMode), .idMode(idMode), .eraseSuspended(eraseSuspended),
		.simulDisabled(simulDisabled));
	host_bus_model i_host (.core_clk(core_clk), .dataOut(dataOut), .chipSel_n(chipSel_n),
		.outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n), .addr(addr), .dataIn(dataIn));
	task chk(input ok, input [8*16-1:0] msg);
		begin
			checks = checks + 1;
			if (!ok) begin
				err_total = err_total + 1;
				$display("BAD %0t %0s", $time, msg);
			end
		end
	endtask
	task idle(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	task cmd(input [7:0] c);
		begin
			i_host.wr(20'h00555, {24'h000000, `CMD_UNLOCK1});
			i_host.wr(20'h002AA, {24'h000000, `CMD_UNLOCK2});
			i_host.wr(20'h00555, {24'h000000, c});
		end
	endtask
	task prog(input [19:0] a, input [31:0] d);
		begin
			cmd(`CMD_PROGRAM);
			i_host.wr(a, d);
			idle(3);
		end
	endtask
	task ready;
		integer n;
		begin
			n = 0;
			while (readyBusy !== 1'b1 && n < 100) begin
				@(negedge core_clk);
				n = n + 1;
			end
			chk(readyBusy === 1'b1, "busy stuck");
		end
	endtask
	task hwr;
		begin
			hwReset_n = 1'b0;
			idle(1);
			hwReset_n = 1'b1;
			idle(1);
		end
	endtask
	task t_power_up;
		begin
			chk(readyBusy === 1'b1 && idMode === 1'b0, "not idle");
			prog(20'h60002, 32'h12345678);
			chk(readyBusy === 1'b0, "no program");
			ready;
			i_host.rd(20'h60002, rv);
			chk(dataOe === 32'hFFFFFFFF, "wide oe");
			chk(rv === 32'h12345678, "wide word");
		end
	endtask
	task t_simul(input top, input [19:0] s, input [19:0] b, input [31:0] bv, input [31:0] nv);
		begin
			topBoot = top;
			prog(s, nv);
			i_host.rd(b, rv);
			chk(rv === bv && readyBusy === 1'b0, "bank blocked");
			i_host.rd(s, rv);
			chk(rv[0] === 1'b0, "no status");
			ready;
			i_host.rd(s, rv);
			chk(rv === nv, "small bank word");
		end
	endtask
	task t_narrow;
		begin
			wideBus = 1'b0;
			i_host.rd(20'h00021, rv);
			chk(dataOe === 32'h0000FFFF, "upper lanes");
			chk(rv[15:0] === 16'hA5A5, "half select");
			prog(20'h00041, 32'h00001234);
			ready;
			i_host.rd(20'h00041, rv);
			chk(rv[15:0] === 16'h1234, "half word");
			wideBus = 1'b1;
		end
	endtask
	task t_bypass;
		begin
			cmd(`CMD_BYPASS);
			idle(1);
			chk(bypassMode === 1'b1, "no bypass");
			i_host.wr(20'h00000, {24'h000000, `CMD_PROGRAM});
			i_host.wr(20'h00030, 32'hC3C33C3C);
			idle(3);
			ready;
			i_host.rd(20'h00030, rv);
			chk(rv === 32'hC3C33C3C, "bypass word");
			hwr;
			chk(bypassMode === 1'b0, "mode kept");
		end
	endtask
	task t_accel_guard;
		begin
			writeProtect_n = 1'b0;
			accel_voltage_pin = 1'b1;
			idle(3);
			chk(bypassMode === 1'b1, "accel bypass");
			i_host.wr(20'h00000, {24'h000000, `CMD_PROGRAM});
			i_host.wr(20'h7FFC5, 32'h00000000);
			idle(3);
			chk(readyBusy === 1'b1, "guard broken");
			accel_voltage_pin = 1'b0;
			writeProtect_n = 1'b1;
			hwr;
		end
	endtask
	task t_ident;
		begin
			cmd(`CMD_AUTOSEL);
			idle(1);
			chk(idMode === 1'b1, "no id mode");
			i_host.rd(20'h0000F, rv);
			chk(rv[0] === ~topBoot, "boot code");
			i_host.rd(20'h00002, rv);
			chk(rv[1:0] === 2'b00, "lock bits");
			hwr;
			chk(idMode === 1'b0, "id kept");
		end
	endtask
	task t_query;
		begin
			i_host.wr(20'h00055, {24'h000000, `CMD_CFI});
			idle(1);
			chk(simulDisabled === 1'b1, "no query mode");
			prog(20'h00010, 32'hA5A50F0F);
			i_host.rd(20'h60002, rv);
			chk(rv === 32'h00000000, "simul not off");
			ready;
			i_host.wr(20'h00000, {24'h000000, `CMD_RESET});
			idle(2);
			chk(simulDisabled === 1'b0, "query kept");
		end
	endtask
	task t_erase;
		begin
			cmd(`CMD_ERASE);
			i_host.wr(20'h00555, {24'h000000, `CMD_UNLOCK1});
			i_host.wr(20'h002AA, {24'h000000, `CMD_UNLOCK2});
			i_host.wr(20'h00010, {24'h000000, `CMD_SECT_ERASE});
			idle(1);
			chk(readyBusy === 1'b0, "no erase");
			i_host.wr(20'h00000, {24'h000000, `CMD_SUSPEND});
			idle(1);
			chk(eraseSuspended === 1'b1 && readyBusy === 1'b1, "no suspend");
			i_host.wr(20'h00000, {24'h000000, `CMD_RESUME});
			idle(1);
			chk(eraseSuspended === 1'b0 && readyBusy === 1'b0, "no resume");
			ready;
		end
	endtask
	task final_report;
		begin
			$display("checks %0d err_total %0d", checks, err_total);
			if (err_total == 0 && checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		#60000;
		err_total = err_total + 1;
		final_report;
	end
	initial begin
		idle(6);
		sys_rst = 1'b0;
		idle(1);
		t_power_up;
		t_simul(1'b1, 20'h00010, 20'h60002, 32'h12345678, 32'hA5A50F0F);
		t_simul(1'b0, 20'h60011, 20'h00010, 32'hA5A50F0F, 32'h5A5AF0F0);
		topBoot = 1'b1;
		t_narrow;
		t_bypass;
		t_accel_guard;
		t_ident;
		t_query;
		t_erase;
		final_report;
	end
endmodule

// File: host_bus_model.sv
// host-side model driving the flash bus strobes
`timescale 1ns/1ps
module host_bus_model (
	input wire core_clk,
	input wire [31:0] dataOut,
	output reg chipSel_n,
	output reg outGate_n,
	output reg writeStrobe_n,
	output reg [19:0] addr,
	output reg [31:0] dataIn
);
	initial begin
		chipSel_n = 1'b1;
		outGate_n = 1'b1;
		writeStrobe_n = 1'b1;
		addr = 20'h00000;
		dataIn = 32'h00000000;
	end
	// one low strobe cycle; the caller's next negedge gives the high gap
	task wr(input [19:0] a, input [31:0] d);
		begin
			@(negedge core_clk);
			addr = a;
			dataIn = d;
			outGate_n = 1'b1;
			chipSel_n = 1'b0;
			writeStrobe_n = 1'b0;
			@(negedge core_clk);
			chipSel_n = 1'b1;
			writeStrobe_n = 1'b1;
			// released bus must not keep showing the old word
			dataIn = ~d;
		end
	endtask
	task rd(input [19:0] a, output [31:0] d);
		begin
			@(negedge core_clk);
			addr = a;
			chipSel_n = 1'b0;
			outGate_n = 1'b0;
			repeat (3) @(negedge core_clk);
			d = dataOut;
			chipSel_n = 1'b1;
			outGate_n = 1'b1;
		end
	endtask
endmodule
